// *** src/fbc_host_ctrl.sv ***
// Overview of operation
// - In bypass mode a program takes two write cycles instead of four.
// - Busy shows on the ready pin and on polling and toggle bits.
// - Reads to the bank not being erased are served without suspending.
// - Control inputs can put the device in standby to save power.
// - Select, write and output strobes define cycles and prevent contention.
`timescale 1ns/10ps
`default_nettype none
module fbc_host_ctrl import fbc_pkg::*; #(
  parameter int AXI_AW = 8,
  parameter int FADDR_W = 19,
  parameter logic [18:0] UNLOCK_A1 = 19'h00001,
  parameter logic [15:0] UNLOCK_D1 = 16'h0001,
  parameter logic [18:0] UNLOCK_A2 = 19'h00002,
  parameter logic [15:0] UNLOCK_D2 = 16'h0002,
  parameter logic [15:0] CMD_PROG = 16'h0010,
  parameter logic [15:0] CMD_ERASE_SETUP = 16'h0020,
  parameter logic [15:0] CMD_CHIP = 16'h0030,
  parameter logic [15:0] CMD_SECTOR = 16'h0040
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [AXI_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [FADDR_W-1:0] flash_addr_o,
  input wire logic [15:0] flash_dq_i,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe_o,
  output logic flash_ce_n_o,
  output logic flash_we_n_o,
  output logic flash_oe_n_o,
  output logic flash_reset_n_o,
  output logic flash_byte_n_o,
  input wire logic ready_busy_out_i
);
  typedef struct packed {
    fbc_state_t st;
    logic [7:0] cnt;
    logic [2:0] step;
    logic [2:0] op;
    logic [2:0] cur_op;
    logic cur_byp;
    logic bypass;
    logic poll_tog;
    logic byte_mode;
    logic flash_rst;
    logic [18:0] addr;
    logic [18:0] cur_addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
    logic rd_req;
    logic poll_rd;
    logic have_tog;
    logic tog;
    logic [3:0] npulse;
    logic aw_got;
    logic w_got;
    logic [AXI_AW-1:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rd;
    logic [1:0] rresp;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic dq_oe;
    logic [18:0] fa;
    logic [15:0] fd;
  } fbc_regs_t;

  fbc_regs_t r_reg;
  fbc_regs_t r_next;
  logic rb_q;
  logic [15:0] dq_q;

  // Busy pin and data lines come from the device's own timing
  fbc_sync #(.WIDTH(1)) u_rb_sync (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .async_i(ready_busy_out_i), .q_o(rb_q));
  fbc_sync #(.WIDTH(16)) u_dq_sync (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .async_i(flash_dq_i), .q_o(dq_q));

  // ==========================================================
  // Helpers
  function automatic logic [2:0] seq_len(input logic [2:0] op, input logic byp);
    if (op == OP_PROG) begin
      return byp ? 3'd2 : 3'd4;
    end else if (op == OP_ESECT || op == OP_ECHIP) begin
      return 3'd6;
    end
    return 3'd1;
  endfunction : seq_len

  function automatic logic [34:0] seq_cyc(input logic [2:0] op, input logic byp,
      input logic [2:0] step, input logic [18:0] a, input logic [15:0] d);
    logic [2:0] k;
    k = (byp && op == OP_PROG) ? step + 3'd2 : step;
    if (op == OP_RAW) begin
      return {a, d};
    end else if (op == OP_PROG) begin
      case (k)
        3'd0: return {UNLOCK_A1, UNLOCK_D1};
        3'd1: return {UNLOCK_A2, UNLOCK_D2};
        3'd2: return {UNLOCK_A1, CMD_PROG};
        default: return {a, d};
      endcase
    end
    case (k)
      3'd0, 3'd3: return {UNLOCK_A1, UNLOCK_D1};
      3'd1, 3'd4: return {UNLOCK_A2, UNLOCK_D2};
      3'd2: return {UNLOCK_A1, CMD_ERASE_SETUP};
      default: return (op == OP_ESECT) ? {a, CMD_SECTOR} : {UNLOCK_A1, CMD_CHIP};
    endcase
  endfunction : seq_cyc

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] be);
    logic [31:0] m;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    return m;
  endfunction : merge

  // ==========================================================
  // Bus slave and flash engine; bus clears go first so hardware sets win
  always_comb begin
    logic [31:0] ctrl_w;
    logic [31:0] cw;
    logic [34:0] cyc;
    ctrl_w = '0;
    cw = '0;
    cyc = '0;
    r_next = r_reg;
    ctrl_w[CTRL_OP_LSB +: 3] = r_reg.op;
    ctrl_w[CTRL_BYPASS_BIT] = r_reg.bypass;
    ctrl_w[CTRL_POLL_TOG_BIT] = r_reg.poll_tog;
    ctrl_w[CTRL_BYTE_BIT] = r_reg.byte_mode;
    ctrl_w[CTRL_FRST_BIT] = r_reg.flash_rst;
    if (s_axi_awvalid_i && !r_reg.aw_got) begin
      r_next.aw_got = 1'b1;
      r_next.awa = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !r_reg.w_got) begin
      r_next.w_got = 1'b1;
      r_next.wd = s_axi_wdata_i;
      r_next.ws = s_axi_wstrb_i;
    end
    if (s_axi_bvalid_o && s_axi_bready_i) begin
      r_next.bvalid = 1'b0;
    end
    // Register write once address and data are both held
    if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = 2'b00;
      case ({r_reg.awa[AXI_AW-1:2], 2'b00})
        FBC_CTRL_OFS: begin
          cw = merge(ctrl_w, r_reg.wd, r_reg.ws);
          r_next.op = cw[CTRL_OP_LSB +: 3];
          r_next.bypass = cw[CTRL_BYPASS_BIT];
          r_next.poll_tog = cw[CTRL_POLL_TOG_BIT];
          r_next.byte_mode = cw[CTRL_BYTE_BIT];
          r_next.flash_rst = cw[CTRL_FRST_BIT];
          if (cw[CTRL_GO_BIT] && r_reg.st == ST_WAITB && cw[2:0] == OP_READ) begin
            r_next.rd_req = 1'b1;
          end else if (cw[CTRL_GO_BIT] && r_reg.st == ST_IDLE && cw[2:0] <= OP_ECHIP) begin
            r_next.cur_op = cw[2:0];
            r_next.cur_byp = cw[CTRL_BYPASS_BIT];
            r_next.cur_addr = r_reg.addr;
            r_next.step = 3'd0;
            r_next.npulse = 4'd0;
            r_next.have_tog = 1'b0;
            r_next.poll_rd = 1'b0;
            r_next.st = (cw[2:0] == OP_READ) ? ST_RLOW : ST_SETUP;
            r_next.cnt = (cw[2:0] == OP_READ) ? RD_CYC - 8'd1 : 8'd0;
            r_next.fa = r_reg.addr;
          end
        end
        FBC_ADDR_OFS: begin
          cw = merge({13'h0000, r_reg.addr}, r_reg.wd, r_reg.ws);
          r_next.addr = cw[18:0];
        end
        FBC_WDATA_OFS: begin
          cw = merge({16'h0000, r_reg.wdata}, r_reg.wd, r_reg.ws);
          r_next.wdata = cw[15:0];
        end
        FBC_STATUS_OFS: begin
          if (r_reg.ws[0] && r_reg.wd[STAT_DONE_BIT]) begin
            r_next.done = 1'b0;
          end
        end
        FBC_RDATA_OFS: ;
        default: r_next.bresp = 2'b10;
      endcase
    end
    // Register read
    if (s_axi_rvalid_o && s_axi_rready_i) begin
      r_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && !r_reg.rvalid) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = 2'b00;
      r_next.rd = '0;
      case ({s_axi_araddr_i[AXI_AW-1:2], 2'b00})
        FBC_CTRL_OFS: r_next.rd = ctrl_w;
        FBC_ADDR_OFS: r_next.rd = {13'h0000, r_reg.addr};
        FBC_WDATA_OFS: r_next.rd = {16'h0000, r_reg.wdata};
        FBC_STATUS_OFS: r_next.rd = {29'h0, rb_q, r_reg.done, r_reg.st != ST_IDLE};
        FBC_RDATA_OFS: r_next.rd = {16'h0000, r_reg.rdata};
        default: r_next.rresp = 2'b10;
      endcase
    end
    // Flash engine
    if (r_reg.cnt != 8'd0) begin
      r_next.cnt = r_reg.cnt - 8'd1;
    end else begin
      case (r_reg.st)
        ST_IDLE: ;
        ST_SETUP: begin
          cyc = seq_cyc(r_reg.cur_op, r_reg.cur_byp, r_reg.step, r_reg.cur_addr, r_reg.wdata);
          r_next.fa = cyc[34:16];
          r_next.fd = cyc[15:0];
          r_next.st = ST_WLOW;
          r_next.cnt = WP_CYC - 8'd1;
          r_next.npulse = r_reg.npulse + 4'd1;
        end
        ST_WLOW: begin
          r_next.st = ST_WHIGH;
          r_next.cnt = WPH_CYC - 8'd1;
        end
        ST_WHIGH: begin
          if (r_reg.step != seq_len(r_reg.cur_op, r_reg.cur_byp) - 3'd1) begin
            r_next.step = r_reg.step + 3'd1;
            r_next.st = ST_SETUP;
          end else if (r_reg.cur_op == OP_RAW) begin
            r_next.st = ST_IDLE;
            r_next.done = 1'b1;
          end else begin
            r_next.st = ST_WAITB;
            r_next.cnt = BUSY_CYC - 8'd1;
          end
        end
        ST_WAITB: begin
          if (r_reg.rd_req) begin
            r_next.rd_req = 1'b0;
            r_next.poll_rd = 1'b0;
            r_next.fa = r_reg.addr;
            r_next.st = ST_RLOW;
            r_next.cnt = RD_CYC - 8'd1;
          end else if (r_reg.poll_tog) begin
            r_next.poll_rd = 1'b1;
            r_next.fa = r_reg.cur_addr;
            r_next.st = ST_RLOW;
            r_next.cnt = RD_CYC - 8'd1;
          end else if (rb_q) begin
            r_next.st = ST_IDLE;
            r_next.done = 1'b1;
          end
        end
        ST_RLOW: begin
          r_next.st = ST_RDONE;
          if (!r_reg.poll_rd) begin
            r_next.rdata = dq_q;
          end
        end
        ST_RDONE: begin
          if (r_reg.poll_rd) begin
            r_next.tog = dq_q[TOGGLE_STATUS_BIT_POS];
            r_next.have_tog = 1'b1;
            if (r_reg.have_tog && r_reg.tog == dq_q[TOGGLE_STATUS_BIT_POS]) begin
              r_next.st = ST_IDLE;
              r_next.done = 1'b1;
            end else begin
              r_next.st = ST_WAITB;
            end
          end else if (r_reg.cur_op != OP_READ) begin
            r_next.st = ST_WAITB;
          end else begin
            r_next.st = ST_IDLE;
            r_next.done = 1'b1;
          end
        end
        default: r_next.st = ST_IDLE;
      endcase
    end
    // Software hardware reset abandons the sequence
    if (r_reg.flash_rst) begin
      r_next.st = ST_IDLE;
      r_next.cnt = 8'd0;
      r_next.rd_req = 1'b0;
    end
    // Pins follow the next state; select high when idle is standby
    r_next.ce_n = !(r_next.st == ST_WLOW || r_next.st == ST_RLOW);
    r_next.we_n = r_next.st != ST_WLOW;
    r_next.oe_n = r_next.st != ST_RLOW;
    r_next.dq_oe = r_next.st == ST_SETUP || r_next.st == ST_WLOW || r_next.st == ST_WHIGH;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      r_reg <= '0;
      r_reg.ce_n <= 1'b1;
      r_reg.we_n <= 1'b1;
      r_reg.oe_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign s_axi_awready_o = !r_reg.aw_got;
  assign s_axi_wready_o = !r_reg.w_got;
  assign s_axi_bvalid_o = r_reg.bvalid;
  assign s_axi_bresp_o = r_reg.bresp;
  assign s_axi_arready_o = !r_reg.rvalid;
  assign s_axi_rvalid_o = r_reg.rvalid;
  assign s_axi_rdata_o = r_reg.rd;
  assign s_axi_rresp_o = r_reg.rresp;
  assign flash_addr_o = r_reg.fa[FADDR_W-1:0];
  assign flash_dq_o = r_reg.fd;
  assign flash_dq_oe_o = r_reg.dq_oe;
  assign flash_ce_n_o = r_reg.ce_n;
  assign flash_we_n_o = r_reg.we_n;
  assign flash_oe_n_o = r_reg.oe_n;
  assign flash_reset_n_o = !r_reg.flash_rst;
  assign flash_byte_n_o = !r_reg.byte_mode;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_we_pulse;
    (!flash_we_n_o)[*4] ##1 flash_we_n_o;
  endsequence

  a_strobe_excl: assert property (!(!flash_we_n_o && !flash_oe_n_o))
    else $error("write and output strobes low together");
  a_dq_no_contend: assert property (flash_dq_oe_o |-> flash_oe_n_o)
    else $error("data driven while output enable is low");
  // A flash reset may cut a pulse short on purpose
  a_we_width: assert property (disable iff (sys_rst_i || r_reg.flash_rst)
    $fell(flash_we_n_o) |-> s_we_pulse)
    else $error("write pulse width wrong");
  a_ce_standby: assert property (r_reg.st == ST_IDLE |-> flash_ce_n_o)
    else $error("select low while idle");
  a_bypass_len: assert property (
    (r_reg.st == ST_WAITB && $past(r_reg.st) == ST_WHIGH && r_reg.cur_op == OP_PROG)
      |-> r_reg.npulse == (r_reg.cur_byp ? 4'd2 : 4'd4))
    else $error("program write count wrong");
  a_wait_ready: assert property (
    (r_reg.st == ST_WAITB && !r_reg.poll_tog && !r_reg.flash_rst ##1 r_reg.st == ST_IDLE)
      |-> $past(rb_q))
    else $error("finished without ready");
  a_read_in_wait: assert property (
    (r_reg.st == ST_WAITB && r_reg.cnt == 8'd0 && r_reg.rd_req && !r_reg.flash_rst)
      |=> r_reg.st == ST_RLOW ##[1:20] r_reg.st == ST_RDONE)
    else $error("read during wait not served");
  a_done_set: assert property (
    (r_reg.st != ST_IDLE && !r_reg.flash_rst ##1 r_reg.st == ST_IDLE) |-> r_reg.done)
    else $error("done not set at completion");
endmodule : fbc_host_ctrl
`default_nettype wire

// *** src/fbc_pkg.sv ***
package fbc_pkg;

  // ==========================================================
  // Register map of the controller (byte addresses, one word each)
  localparam logic [7:0] FBC_CTRL_OFS = 8'h00;
  localparam logic [7:0] FBC_ADDR_OFS = 8'h04;
  localparam logic [7:0] FBC_WDATA_OFS = 8'h08;
  localparam logic [7:0] FBC_STATUS_OFS = 8'h0c;
  localparam logic [7:0] FBC_RDATA_OFS = 8'h10;

  // CTRL field positions
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_GO_BIT = 3;
  localparam int CTRL_BYPASS_BIT = 4;
  localparam int CTRL_POLL_TOG_BIT = 5;
  localparam int CTRL_BYTE_BIT = 6;
  localparam int CTRL_FRST_BIT = 7;
  // STATUS field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_RB_BIT = 2;
  // Status bit on the flash data lines
  localparam int TOGGLE_STATUS_BIT_POS = 6;
  localparam int INVERTED_DATA_POLL_BIT_POS = 7;

  // Operations
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_RAW = 3'h1;
  localparam logic [2:0] OP_PROG = 3'h2;
  localparam logic [2:0] OP_ESECT = 3'h3;
  localparam logic [2:0] OP_ECHIP = 3'h4;

  // ==========================================================
  // Timing, at a 10 ns clock
  localparam int CLK_NS = 10;
  localparam int T_ACC_NS = 70;
  localparam int T_WP_NS = 35;
  localparam int T_WPH_NS = 20;
  localparam int T_BUSY_NS = 90;
  localparam int SYNC_DEPTH = 4;
  localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] WPH_CYC = 8'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] BUSY_CYC = 8'((T_BUSY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RD_CYC = ACC_CYC + 8'(SYNC_DEPTH);

  // Engine states, Gray along the chain ST_IDLE, ST_SETUP, ST_WLOW, ST_WHIGH, ST_WAITB, ST_RLOW, ST_RDONE
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_WLOW = 3'h3,
    ST_WHIGH = 3'h2,
    ST_WAITB = 3'h6,
    ST_RLOW = 3'h7,
    ST_RDONE = 3'h5
  } fbc_state_t;

endpackage : fbc_pkg

// *** src/fbc_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module fbc_sync import fbc_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } fbc_sync_t;
  fbc_sync_t r_reg;
  fbc_sync_t r_next;

  // ==========================================================
  // Three stages; a new value counts only once stage two and three agree
  always_comb begin
    r_next = r_reg;
    r_next.s1 = async_i;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    if (r_reg.s2 == r_reg.s3) begin
      r_next.q = r_reg.s3;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_o = r_reg.q;
endmodule : fbc_sync
`default_nettype wire

// *** tb/fbc_flash_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module fbc_flash_model #(
  parameter logic [15:0] CBYP = 16'h0050,
  parameter logic [15:0] CBYPX = 16'h0090,
  parameter logic [15:0] CSUSP = 16'h0060,
  parameter logic [15:0] CRES = 16'h0070,
  parameter int PROG_CYC = 40,
  parameter int ERASE_CYC = 300,
  parameter int PROT_SECT = 9
) (
  input wire logic [18:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic reset_n_i,
  input wire logic byte_n_i,
  output logic [15:0] dq_o,
  output logic drive_o,
  output logic ready_busy_out_o
);
  // ==========================================================
  // Array state; a word missing from the map reads as erased
  logic [15:0] mem [int];
  logic [15:0] tdat = 16'h0, val = 16'h0, last = 16'h0;
  logic [17:0] tgt = 18'h0, ra;
  logic byp = 1'b0, susp = 1'b0, tog = 1'b0, prot = 1'b0, stat;
  logic wr_n, vcc_ok = 1'b0;
  int step = 0, cnt = 0, kind = 0;

  // Writes latch on whichever of select and write strobe rises first
  assign wr_n = we_n_i | ce_n_i;

  // Supply-low inhibit: no write counts until power-up has released reset
  always @(posedge reset_n_i) vcc_ok = 1'b1;

  // Small boot sectors first, then uniform code sectors from sector 8
  function automatic int sect_of(input logic [17:0] a);
    if (a < 18'h04000) return int'(a >> 12);
    if (a < 18'h08000) return 4 + int'((a - 18'h04000) >> 13);
    if (a < 18'h10000) return 6 + int'((a - 18'h08000) >> 14);
    return 8 + int'((a - 18'h10000) >> 15);
  endfunction : sect_of

  function automatic logic [15:0] word_at(input logic [17:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 16'hffff;
  endfunction : word_at

  task automatic launch(input int k, input logic [17:0] a, input logic [15:0] d);
    kind = k;
    tgt = a;
    tdat = d;
    prot = (sect_of(a) == PROT_SECT) && k != 3;
    cnt = (k == 1) ? PROG_CYC : ERASE_CYC;
  endtask : launch

  // ==========================================================
  // Command decoder on the closing edge of each write strobe
  always @(posedge wr_n) begin : decode
    logic [17:0] wa;
    wa = byte_n_i ? addr_i[17:0] : addr_i[18:1];
    if (vcc_ok && reset_n_i) begin
      if (cnt > 0) begin
        if (kind > 1 && dq_i == CSUSP) susp = 1'b1;
        if (dq_i == CRES) susp = 1'b0;
      end else if (dq_i == CBYP || dq_i == CBYPX) begin
        byp = (dq_i == CBYP);
        step = 0;
      end else begin
        case (step)
          0, 3: begin
            if (wa == 18'h1 && dq_i == 16'h1) step++;
            else if (step == 0 && byp && wa == 18'h1 && dq_i == 16'h10) step = 6;
            else step = 0;
          end
          1, 4: step = (wa == 18'h2 && dq_i == 16'h2) ? step + 1 : 0;
          2: step = (wa != 18'h1) ? 0 : (dq_i == 16'h10) ? 6 : (dq_i == 16'h20) ? 3 : 0;
          5: begin
            step = 0;
            if (wa == 18'h1 && dq_i == 16'h30) launch(3, wa, dq_i);
            else if (dq_i == 16'h40) launch(2, wa, dq_i);
          end
          default: begin
            step = 0;
            launch(1, wa, dq_i);
          end
        endcase
      end
    end
  end

  // Self-timed algorithm; a suspend freezes the count, a protected target ends untouched
  always begin : algo
    int q[$];
    #10;
    if (cnt > 0 && !susp) begin
      cnt = cnt - 1;
      if (cnt == 0 && !prot) begin
        if (kind == 1) mem[int'(tgt)] = word_at(tgt) & tdat;
        q.delete();
        foreach (mem[k]) if (kind == 3 ? sect_of(18'(k)) != PROT_SECT : kind == 2 &&
            sect_of(18'(k)) == sect_of(tgt)) q.push_back(k);
        foreach (q[i]) mem.delete(q[i]);
      end
    end
  end

  // Hardware reset abandons any algorithm
  always @(negedge reset_n_i) begin : hw_reset
    cnt = 0;
    step = 0;
    susp = 1'b0;
    byp = 1'b0;
  end

  // ==========================================================
  // Read path; a released bus shows the inverse of the last value
  always @(negedge oe_n_i) if (cnt > 0) tog = ~tog;
  assign ra = byte_n_i ? addr_i[17:0] : addr_i[18:1];
  assign drive_o = !ce_n_i && !oe_n_i && we_n_i && reset_n_i;
  assign ready_busy_out_o = !(cnt > 0 && !susp);
  // Reads answer at once, so waking from sleep costs no more than an access
  always @(ra, drive_o, cnt, tog, susp) begin : rd_path
    stat = cnt > 0 && !susp && (kind == 3 || (sect_of(ra) < 8) == (sect_of(tgt) < 8));
    val = stat ? {8'h00, kind == 1 ? ~tdat[7] : 1'b0, tog, 6'h00} : word_at(ra);
    if (drive_o) last = val;
    dq_o = drive_o ? val : ~last;
  end
endmodule : fbc_flash_model
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench import fbc_pkg::*;;
  // ==========================================================
  // Clock, reset and bus signals
  logic clk = 1'b0, rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic awready, wready, bvalid, arready, rvalid, dq_oe, ce_n, we_n, oe_n, fr_n, byte_n, rb, mdrv;
  logic [1:0] bresp, rresp, r;
  logic [18:0] faddr;
  logic [15:0] dq_c, dq_m, dq_bus;
  int err_count = 0, n_tests = 0;
  always #5 clk = ~clk;
  // Controller data wins only while the device is not driving
  assign dq_bus = (dq_oe && !mdrv) ? dq_c : dq_m;

  fbc_host_ctrl dut (.core_clk_i(clk), .sys_rst_i(rst), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .flash_addr_o(faddr), .flash_dq_i(dq_bus), .flash_dq_o(dq_c),
    .flash_dq_oe_o(dq_oe), .flash_ce_n_o(ce_n), .flash_we_n_o(we_n), .flash_oe_n_o(oe_n),
    .flash_reset_n_o(fr_n), .flash_byte_n_o(byte_n), .ready_busy_out_i(rb));
  fbc_flash_model flash (.addr_i(faddr), .dq_i(dq_bus), .ce_n_i(ce_n), .we_n_i(we_n),
    .oe_n_i(oe_n), .reset_n_i(fr_n), .byte_n_i(byte_n), .dq_o(dq_m), .drive_o(mdrv),
    .ready_busy_out_o(rb));

  // ==========================================================
  // Bus tasks; each starts one edge on so no signal is set twice in a step
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Load address and data, then start the operation named in ctl
  task automatic op(input logic [18:0] a, input logic [15:0] d, input logic [7:0] ctl);
    axi_wr(FBC_ADDR_OFS, {13'h0, a}, r);
    axi_wr(FBC_WDATA_OFS, {16'h0, d}, r);
    axi_wr(FBC_CTRL_OFS, {24'h0, ctl}, r);
  endtask : op

  // Poll until done, then clear it for the next operation
  task automatic wait_done();
    v = 32'h0;
    while (v[STAT_DONE_BIT] !== 1'b1) axi_rd(FBC_STATUS_OFS, v, r);
    axi_wr(FBC_STATUS_OFS, 32'h2, r);
  endtask : wait_done

  task automatic peek(input logic [18:0] a, input logic [15:0] e);
    op(a, 16'h0, {5'h01, OP_READ});
    wait_done();
    axi_rd(FBC_RDATA_OFS, v, r);
    `CHK("array word", {16'h0, e}, v)
  endtask : peek

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // ==========================================================
  // Test sequence
  initial begin : main
    repeat (10) @(posedge clk);
    `CHK("idle pins", 6'b111011, {ce_n, we_n, oe_n, dq_oe, fr_n, byte_n})
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    axi_rd(FBC_CTRL_OFS, v, r);
    `CHK("ctrl reset", 32'h0, v)
    axi_rd(FBC_STATUS_OFS, v, r);
    `CHK("status reset", 32'h4, v)
    axi_rd(8'h14, v, r);
    `CHK("unmapped read", 34'h200000000, {r, v})
    axi_wr(8'h14, 32'hffff, r);
    `CHK("unmapped write", 2'b10, r)
    op(19'h10005, 16'h1234, 8'h0a);
    wait_done();
    peek(19'h10005, 16'h1234);
    op(19'h10005, 16'h00ff, 8'h2a); // Toggle polling this time
    wait_done();
    peek(19'h10005, 16'h0034);
    op(19'h0, 16'h0050, 8'h09); // Raw write enters bypass
    wait_done();
    op(19'h20000, 16'ha5a5, 8'h1a);
    axi_rd(FBC_CTRL_OFS, v, r);
    `CHK("ctrl go reads 0", 32'h12, v)
    wait_done();
    peek(19'h20000, 16'ha5a5);
    op(19'h0, 16'h0090, 8'h09);
    wait_done();
    op(19'h00100, 16'h5555, 8'h0a);
    wait_done();
    op(19'h10000, 16'h0, 8'h0b); // Erase one code sector
    // Wait for the device to go busy, so the read below meets the engine in its wait
    v = 32'h4;
    while (v[STAT_RB_BIT] !== 1'b0) axi_rd(FBC_STATUS_OFS, v, r);
    `CHK("busy in erase", 1'b1, v[STAT_BUSY_BIT])
    peek(19'h00100, 16'h5555);
    peek(19'h10005, 16'hffff);
    peek(19'h20000, 16'ha5a5);
    op(19'h18000, 16'h0, 8'h0a); // Protected sector
    wait_done();
    peek(19'h18000, 16'hffff);
    op(19'h20000, 16'h0, 8'h0b);
    axi_wr(FBC_CTRL_OFS, 32'h80, r);
    `CHK("device reset pin", 1'b0, fr_n)
    axi_wr(FBC_CTRL_OFS, 32'h0, r);
    axi_wr(FBC_STATUS_OFS, 32'h2, r);
    repeat (8) @(posedge clk);
    axi_rd(FBC_STATUS_OFS, v, r);
    `CHK("abort status", 3'h4, v[2:0])
    peek(19'h20000, 16'ha5a5);
    op(19'h0, 16'h0, 8'h0c); // Whole chip
    wait_done();
    peek(19'h20000, 16'hffff);
    peek(19'h00100, 16'hffff);
    axi_wr(FBC_CTRL_OFS, 32'h40, r);
    `CHK("byte mode pin", 1'b0, byte_n)
    close_out();
  end

  // A hang past several times the expected run time ends the test
  initial begin : watchdog
    #400000;
    err_count++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
